/* ptm_cmp_buffer.sv */
// double-buffered cycle compare value
`timescale 1ns/1ps
module ptm_cmp_buffer
  import ptm_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  ptm_ctl_if.cbuf   ctl
);
  ptm_count_t buf_reg;
  ptm_count_t act_reg;
  logic       load_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_reg <= CYCLE_RST;
    end else if (ce_in && ctl.cmp_wr) begin
      buf_reg <= ctl.cmp_wdata;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      load_reg <= 1'b0;
    end else if (ce_in) begin
      load_reg <= ctl.match_clear;
    end
  end

  // stopped: write straight through; running: wait one cycle past the clear
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      act_reg <= CYCLE_RST;
    end else if (ce_in) begin
      if (!ctl.count_running && ctl.cmp_wr) begin
        act_reg <= ctl.cmp_wdata;
      end else if (ctl.count_running && load_reg) begin
        act_reg <= buf_reg;
      end
    end
  end

  assign ctl.cmp_buffer = buf_reg;
  assign ctl.cmp_active = act_reg;
endmodule : ptm_cmp_buffer

/* ptm_ctl_if.sv */
// carrier between the timer core, its prescaler and its compare buffer
`timescale 1ns/1ps
interface ptm_ctl_if;
  import ptm_pkg::*;
  logic       prescaler_run;
  logic [2:0] prescale_select;
  ptm_tap_e   count_clock_select;
  logic       src_tick;
  logic       count_running;
  logic       match_clear;
  logic       cmp_wr;
  ptm_count_t cmp_wdata;
  ptm_count_t cmp_buffer;
  ptm_count_t cmp_active;

  modport core (output prescaler_run, prescale_select, count_clock_select, count_running,
                output match_clear, cmp_wr, cmp_wdata,
                input  src_tick, cmp_buffer, cmp_active);
  modport pre  (input prescaler_run, prescale_select, count_clock_select, output src_tick);
  modport cbuf (input count_running, match_clear, cmp_wr, cmp_wdata, output cmp_buffer, cmp_active);
endinterface : ptm_ctl_if

/* ptm_pkg.sv */
// constants and types for the pulse timer prescaler and up-counter
// Summary of operation
// - counter is sixteen bit binary up-counter
// - two-bit field picks one of four taps
// - prescaler divides by 1 to 32 per code
// - taps are prescaled clock over 1,2,4,8
// - writing count_run one starts counting
// - writing count_run zero stops and clears counter
// - restart request clears counter, counting resumes
// - counter clears when equal to cycle compare
// - prescaler runs only while prescaler_run set
// - tap div1 gives period of M+1
// - slower taps give period of M
// - cycle compare buffered while running, loads after match clear; when stopped, writes go straight through
package ptm_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int          ADDR_W = 5;
  localparam int          DATA_W = 32;
  localparam int          CNT_W  = 16;
  localparam int          DIV_W  = 8;

  // byte addresses, one aligned word each
  localparam logic [ADDR_W-1:0] OFS_RUN     = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_PULSE   = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_RESTART = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_CYCLE   = 5'h0c;
  localparam logic [ADDR_W-1:0] OFS_COUNT   = 5'h10;

  // field positions
  localparam int COUNT_RUN_BIT   = 0;
  localparam int PRESC_RUN_BIT   = 1;
  localparam int CLK_SEL_LSB     = 0;
  localparam int PSEL_LSB        = 4;
  localparam int RESTART_REQ_BIT = 0;

  // values after reset, plus the largest prescale code
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CYCLE_RST = 16'hffff;
  localparam logic [2:0]       PSEL_RST  = 3'h0;
  localparam logic [1:0]       CSEL_RST  = 2'h0;
  localparam logic [2:0]       PSEL_MAX  = 3'h5;
  localparam logic [DIV_W-1:0] DIV_RST   = 8'h00;

  typedef logic [CNT_W-1:0] ptm_count_t;

  typedef enum logic [1:0] {
    TAP_DIV1 = 2'h0,
    TAP_DIV2 = 2'h1,
    TAP_DIV4 = 2'h2,
    TAP_DIV8 = 2'h3
  } ptm_tap_e;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } ptm_bus_e;
endpackage : ptm_pkg

/* ptm_prescaler.sv */
// prescaler divider and source tap selection, one tick per source clock
`timescale 1ns/1ps
module ptm_prescaler
  import ptm_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic ce_in,
  ptm_ctl_if.pre    ctl
);
  logic [DIV_W-1:0] div_reg;
  logic [2:0]       psel;
  logic [3:0]       shift;
  logic [DIV_W-1:0] mask;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg <= DIV_RST;
    end else if (ce_in) begin
      if (!ctl.prescaler_run) begin
        div_reg <= DIV_RST;
      end else begin
        div_reg <= div_reg + 8'h01;
      end
    end
  end

  // codes above the largest ratio behave as the largest ratio
  always_comb begin
    psel  = (ctl.prescale_select > PSEL_MAX) ? PSEL_MAX : ctl.prescale_select;
    shift = {1'b0, psel} + {2'b00, ctl.count_clock_select};
    mask  = DIV_W'((9'h001 << shift) - 9'h001);
  end

  // the divider wraps at 256, so every ratio up to 1/256 stays aligned
  assign ctl.src_tick = ctl.prescaler_run && ((div_reg & mask) == mask);
endmodule : ptm_prescaler

/* ptm_timer_checker.sv */
// port assertions for the pulse timer core
`timescale 1ns/1ps
module ptm_timer_checker
  import ptm_pkg::*;
(
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic              ce_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic              avs_read_in,
  input wire logic              avs_write_in,
  input wire logic [DATA_W-1:0] avs_writedata_in,
  input wire logic [3:0]        avs_byteenable_in,
  input wire logic [DATA_W-1:0] avs_readdata_out,
  input wire logic              avs_waitrequest_out,
  input wire logic [CNT_W-1:0]  up_count_value_out,
  input wire logic              count_match_out,
  input wire logic              counting_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic wr_done;
  logic pr_reg;
  assign wr_done = avs_write_in && !avs_waitrequest_out && ce_in && avs_byteenable_in[0];
  // shadow of prescaler_run, rebuilt from completed writes
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) pr_reg <= 1'b0;
    else if (wr_done && avs_address_in == OFS_RUN) pr_reg <= avs_writedata_in[PRESC_RUN_BIT];
  run_start_a: assert property (wr_done && avs_address_in == OFS_RUN |=>
    counting_out == $past(avs_writedata_in[COUNT_RUN_BIT])) else $error("run bit not taken");
  stop_zero_a: assert property (!counting_out |-> up_count_value_out == 16'h0000)
    else $error("counter not zero while stopped");
  restart_zero_a: assert property (wr_done && avs_address_in == OFS_RESTART && avs_writedata_in[0]
    && counting_out |=> up_count_value_out == 16'h0000) else $error("restart did not clear");
  step_one_a: assert property (counting_out && $changed(up_count_value_out) && up_count_value_out != 16'h0000
    |-> up_count_value_out == $past(up_count_value_out) + 16'h0001) else $error("counter step not one");
  match_clear_a: assert property ($rose(count_match_out) |-> up_count_value_out == 16'h0000)
    else $error("match without clear");
  match_pulse_a: assert property (count_match_out |=> !count_match_out)
    else $error("match pulse too long");
  frozen_cnt_a: assert property (!pr_reg && !wr_done |=> $stable(up_count_value_out))
    else $error("counter moved with prescaler stopped");
  wait_one_a: assert property ($rose(avs_read_in || avs_write_in) && ce_in
    |-> avs_waitrequest_out ##1 !avs_waitrequest_out) else $error("bus answer late");
  idle_ready_a: assert property (!(avs_read_in || avs_write_in) |-> !avs_waitrequest_out)
    else $error("waitrequest while idle");
  rd_hold_a: assert property (!avs_read_in |=> $stable(avs_readdata_out))
    else $error("read data moved without read");
endmodule : ptm_timer_checker

bind ptm_timer_top ptm_timer_checker chk (.*);

/* ptm_timer_top.sv */
// timer channel core: avalon-mm registers, run control and 16-bit up-counter
`timescale 1ns/1ps
module ptm_timer_top
  import ptm_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              ce_in,
  input  wire logic [ADDR_W-1:0] avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [DATA_W-1:0] avs_writedata_in,
  input  wire logic [3:0]        avs_byteenable_in,
  output logic      [DATA_W-1:0] avs_readdata_out,
  output logic                   avs_waitrequest_out,
  output logic      [CNT_W-1:0]  up_count_value_out,
  output logic                   count_match_out,
  output logic                   counting_out
);
  ptm_ctl_if ctl ();

  ptm_bus_e            bus_reg;
  ptm_bus_e            bus_next;
  logic [DATA_W-1:0]   rdata_reg;
  logic [DATA_W-1:0]   rdata_next;
  logic                bus_req;
  logic                bus_wr;
  logic                count_run_reg;
  logic                count_run_next;
  logic                prescaler_run_reg;
  logic [2:0]          prescale_select_reg;
  ptm_tap_e            count_clock_select_reg;
  ptm_count_t          up_count_reg;
  ptm_count_t          up_count_next;
  logic                restart_hit;
  logic                match;
  logic                clear_now;
  logic                match_reg;

  // ---------------- bus slave ----------------
  // one wait state: the request is seen, then answered on the next edge
  assign bus_req             = avs_read_in || avs_write_in;
  // a frozen clock enable keeps the master waiting, so no write is lost
  assign avs_waitrequest_out = bus_req && !((bus_reg == BUS_ACK) && ce_in);
  assign bus_wr              = ce_in && avs_write_in && (bus_reg == BUS_ACK);

  always_comb begin
    bus_next = bus_reg;
    case (bus_reg)
      BUS_IDLE: begin
        if (bus_req) begin
          bus_next = BUS_ACK;
        end
      end
      BUS_ACK: begin
        bus_next = BUS_IDLE;
      end
      default: begin
        bus_next = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bus_reg <= BUS_IDLE;
    end else if (ce_in) begin
      bus_reg <= bus_next;
    end
  end

  // read data are captured one edge early so they stand at the answering edge
  always_comb begin
    rdata_next = '0;
    case (avs_address_in)
      OFS_RUN: begin
        rdata_next[COUNT_RUN_BIT] = count_run_reg;
        rdata_next[PRESC_RUN_BIT] = prescaler_run_reg;
      end
      OFS_PULSE: begin
        rdata_next[CLK_SEL_LSB +: 2] = count_clock_select_reg;
        rdata_next[PSEL_LSB +: 3]    = prescale_select_reg;
      end
      OFS_CYCLE: begin
        rdata_next[CNT_W-1:0] = ctl.cmp_active;
      end
      OFS_COUNT: begin
        rdata_next[CNT_W-1:0] = up_count_reg;
      end
      default: begin
        rdata_next = '0;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_reg <= '0;
    end else if (ce_in && avs_read_in && (bus_reg == BUS_IDLE)) begin
      rdata_reg <= rdata_next;
    end
  end

  assign avs_readdata_out = rdata_reg;

  // ---------------- control registers ----------------
  always_comb begin
    count_run_next = count_run_reg;
    if (bus_wr && (avs_address_in == OFS_RUN) && avs_byteenable_in[0]) begin
      count_run_next = avs_writedata_in[COUNT_RUN_BIT];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_run_reg     <= 1'b0;
      prescaler_run_reg <= 1'b0;
    end else if (ce_in) begin
      count_run_reg <= count_run_next;
      if (bus_wr && (avs_address_in == OFS_RUN) && avs_byteenable_in[0]) begin
        prescaler_run_reg <= avs_writedata_in[PRESC_RUN_BIT];
      end
    end
  end

  // the gear and tap settings may change at any time; a change mid-count
  // only shifts the next tick, it never corrupts the count
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_clock_select_reg <= ptm_tap_e'(CSEL_RST);
      prescale_select_reg    <= PSEL_RST;
    end else if (ce_in && bus_wr && (avs_address_in == OFS_PULSE) && avs_byteenable_in[0]) begin
      count_clock_select_reg <= ptm_tap_e'(avs_writedata_in[CLK_SEL_LSB +: 2]);
      prescale_select_reg    <= avs_writedata_in[PSEL_LSB +: 3];
    end
  end

  // restart is a write-one action with no stored bit; it reads as zero
  assign restart_hit = bus_wr && (avs_address_in == OFS_RESTART) && avs_byteenable_in[0]
                       && avs_writedata_in[RESTART_REQ_BIT];

  // compare writes land in the buffer, merged byte by byte
  assign ctl.cmp_wr    = bus_wr && (avs_address_in == OFS_CYCLE) && (|avs_byteenable_in[1:0]);
  assign ctl.cmp_wdata = {avs_byteenable_in[1] ? avs_writedata_in[15:8] : ctl.cmp_buffer[15:8],
                          avs_byteenable_in[0] ? avs_writedata_in[7:0]  : ctl.cmp_buffer[7:0]};

  assign ctl.prescaler_run      = prescaler_run_reg;
  assign ctl.prescale_select    = prescale_select_reg;
  assign ctl.count_clock_select = count_clock_select_reg;
  assign ctl.count_running      = count_run_reg;

  // ---------------- up-counter ----------------
  // with tap div1 the clear waits for the next source clock (M+1 period);
  // with slower taps it follows the match at once, inside the same source clock
  assign match     = count_run_reg && (up_count_reg == ctl.cmp_active);
  assign clear_now = match && (ctl.src_tick || (count_clock_select_reg != TAP_DIV1));
  assign ctl.match_clear = clear_now && count_run_next && !restart_hit;

  always_comb begin
    up_count_next = up_count_reg;
    if (!count_run_next) begin
      up_count_next = COUNT_RST;
    end else if (restart_hit) begin
      up_count_next = COUNT_RST;
    end else if (clear_now) begin
      up_count_next = COUNT_RST;
    end else if (ctl.src_tick) begin
      up_count_next = up_count_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      up_count_reg <= COUNT_RST;
    end else if (ce_in) begin
      up_count_reg <= up_count_next;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      match_reg <= 1'b0;
    end else if (ce_in) begin
      match_reg <= ctl.match_clear;
    end
  end

  assign up_count_value_out = up_count_reg;
  assign count_match_out    = match_reg;
  assign counting_out       = count_run_reg;

  // ---------------- sub-blocks ----------------
  ptm_prescaler u_prescaler (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .ctl    (ctl.pre)
  );

  ptm_cmp_buffer u_cmp_buffer (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .ce_in  (ce_in),
    .ctl    (ctl.cbuf)
  );
endmodule : ptm_timer_top

/* tb.sv */
// self-checking bench for the pulse timer core
`timescale 1ns/1ps
module tb;
  import ptm_pkg::*;
  logic              clk_in = 1'b0;
  logic              rst_in = 1'b1;
  logic              ce_in = 1'b1;
  logic [ADDR_W-1:0] avs_address_in = '0;
  logic              avs_read_in = 1'b0;
  logic              avs_write_in = 1'b0;
  logic [DATA_W-1:0] avs_writedata_in = '0;
  logic [3:0]        avs_byteenable_in = 4'hf;
  logic [DATA_W-1:0] avs_readdata_out;
  logic              avs_waitrequest_out;
  logic [CNT_W-1:0]  up_count_value_out;
  logic              count_match_out;
  logic              counting_out;
  logic [DATA_W-1:0] rd;
  int                miscompares = 0;
  int                checks_done = 0;
  int                cycles = 0;

  ptm_timer_top dut (.*);

  initial begin
    forever #20 clk_in = ~clk_in;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      wrap_up();
    end
  end

  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     input logic [3:0] be = 4'hf);
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= w;
    avs_read_in <= !w;
    do @(posedge clk_in); while (avs_waitrequest_out !== 1'b0);
    rd = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
  endtask : bus

  task automatic tick_gap(output int g);
    logic [CNT_W-1:0] v;
    @(negedge clk_in);
    v = up_count_value_out;
    do @(negedge clk_in); while (up_count_value_out === v);
    v = up_count_value_out;
    g = 0;
    do begin
      @(negedge clk_in);
      g++;
    end while (up_count_value_out === v);
  endtask : tick_gap

  task automatic match_gap(output int g);
    g = 0;
    do @(negedge clk_in); while (count_match_out !== 1'b1);
    do begin
      @(negedge clk_in);
      g++;
    end while (count_match_out !== 1'b1);
  endtask : match_gap

  task automatic t_reset();
    bus(1'b0, OFS_RUN, 32'h0); check(rd, 32'h0);
    bus(1'b0, OFS_CYCLE, 32'h0); check(rd, {16'h0, CYCLE_RST});
    bus(1'b0, OFS_COUNT, 32'h0); check(rd, 32'h0);
    bus(1'b0, 5'h14, 32'h0); check(rd, 32'h0);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_taps();
    int g;
    bus(1'b1, OFS_CYCLE, 32'hffff);
    for (int p = 0; p < 6; p++) begin
      for (int t = 0; t < 4; t++) begin
        // full-rate div1 is a prohibited setting
        if (p + t == 0) continue;
        bus(1'b1, OFS_PULSE, {25'h0, 3'(p), 2'h0, 2'(t)});
        bus(1'b1, OFS_RUN, 32'h3);
        tick_gap(g);
        check(g, 1 << (p + t));
        bus(1'b1, OFS_RUN, 32'h0);
      end
    end
    $display("t_taps done");
  endtask : t_taps

  task automatic t_match(input logic [2:0] p, input logic [1:0] t, input logic [15:0] m, input int exp);
    int g;
    bus(1'b1, OFS_PULSE, {25'h0, p, 2'h0, t});
    bus(1'b1, OFS_CYCLE, {16'h0, m});
    bus(1'b1, OFS_RUN, 32'h3);
    match_gap(g);
    check(g, exp);
    bus(1'b1, OFS_RUN, 32'h0);
    $display("t_match done");
  endtask : t_match

  task automatic t_buffer();
    int g;
    bus(1'b1, OFS_PULSE, {25'h0, 3'h1, 2'h0, 2'h1});
    bus(1'b1, OFS_CYCLE, 32'h5);
    bus(1'b1, OFS_RUN, 32'h3);
    bus(1'b1, OFS_CYCLE, 32'h2);
    bus(1'b0, OFS_CYCLE, 32'h0); check(rd, 32'h5);
    match_gap(g);
    check(g, 8);
    bus(1'b0, OFS_CYCLE, 32'h0); check(rd, 32'h2);
    bus(1'b1, OFS_RUN, 32'h0);
    $display("t_buffer done");
  endtask : t_buffer

  task automatic t_ctl();
    bus(1'b1, OFS_PULSE, {25'h0, 3'h2, 2'h0, 2'h0});
    bus(1'b1, OFS_CYCLE, 32'hffff);
    bus(1'b1, OFS_RUN, 32'h1);
    repeat (20) @(posedge clk_in);
    check(up_count_value_out, 32'h0);
    check(counting_out, 1'b1);
    // lane 0 disabled, so the write must be dropped
    bus(1'b1, OFS_RUN, 32'h3, 4'he);
    bus(1'b0, OFS_RUN, 32'h0); check(rd, 32'h1);
    bus(1'b1, OFS_RUN, 32'h3);
    repeat (40) @(posedge clk_in);
    bus(1'b0, OFS_COUNT, 32'h0); check(rd > 32'h8, 1'b1);
    bus(1'b1, OFS_RESTART, 32'h1);
    @(negedge clk_in); check(up_count_value_out, 32'h0);
    bus(1'b0, OFS_RESTART, 32'h0); check(rd, 32'h0);
    repeat (20) @(posedge clk_in);
    bus(1'b0, OFS_COUNT, 32'h0); check(rd > 32'h2, 1'b1);
    bus(1'b1, OFS_RUN, 32'h2);
    @(negedge clk_in); check(up_count_value_out, 32'h0);
    check(counting_out, 1'b0);
    $display("t_ctl done");
  endtask : t_ctl

  // clock enable low must freeze the running counter, high must let it go on
  task automatic t_freeze();
    logic [CNT_W-1:0] v;
    bus(1'b1, OFS_PULSE, {25'h0, 3'h0, 2'h0, 2'h1});
    bus(1'b1, OFS_RUN, 32'h3);
    repeat (10) @(posedge clk_in);
    ce_in <= 1'b0;
    @(negedge clk_in);
    v = up_count_value_out;
    repeat (12) @(negedge clk_in);
    check(up_count_value_out, v);
    check(counting_out, 1'b1);
    @(posedge clk_in);
    ce_in <= 1'b1;
    repeat (12) @(negedge clk_in);
    check(up_count_value_out > v, 1'b1);
    bus(1'b1, OFS_RUN, 32'h0);
    $display("t_freeze done");
  endtask : t_freeze

  initial begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_taps();
    t_match(3'h2, 2'h0, 16'h3, 16);
    t_match(3'h1, 2'h1, 16'h3, 12);
    t_match(3'h0, 2'h3, 16'h5, 40);
    t_buffer();
    t_ctl();
    t_freeze();
    wrap_up();
  end
endmodule : tb
